/* hw/dual_space_data_memory.v */
// What this block does
// RQ1: Memory has X and Y spaces, separable or one unified linear range.
// RQ2: Two address generators with own paths fetch two words per cycle.
// RQ3: X serves all instructions and modes, with distinct read and write buses.
// RQ4: X read bus carries all unified reads and the X operand prefetch.
// RQ5: Y gives a second concurrent read path for dual-operand instructions.
// RQ6: Modulo addressing is available in both X and Y spaces.
// RQ7: Bit-reversed addressing applies only to writes into X space.
// RQ8: All writes decode against the combined X and Y space.
// RQ9: X/Y boundary is a fixed parameter, never software controlled.
// RQ10: Addresses are 16-bit, byte granular, 64 KB or 32K words.
// RQ11: A 2 KB dual-ported region sits at the top of Y data RAM.
// RQ12: Processor and DMA reach the shared region in one cycle, separately.
// RQ13: DMA accesses never take processor cycles or stall it.
// RQ14: On same-location writes the processor write takes precedence.
// RQ15: DMA uses the shared region for outgoing and incoming peripheral data.
// RQ16: In a collision the DMA write data is discarded.
// RQ17: Address bit 0 selects the byte lane; words use even addresses.
`timescale 1ns/1ps
`default_nettype none
`include "dual_space_consts.vh"
module dual_space_data_memory #(
  parameter [15:0] Y_BASE  = `Y_BASE_DEFAULT,
  parameter [15:0] RAM_TOP = `RAM_TOP_DEFAULT
) (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst,
  // Modulo bounds, shared by all three generators
  input  wire [15:0] mod_start,
  input  wire [15:0] mod_end,
  // X read generator, unified view
  input  wire        xr_en,
  input  wire        xr_byte,
  input  wire        xr_mod,
  input  wire [15:0] xr_ea,
  output reg  [15:0] xr_rdata,
  output reg         xr_valid,
  // X write generator, unified view
  input  wire        xw_en,
  input  wire        xw_byte,
  input  wire        xw_mod,
  input  wire        xw_bitrev,
  input  wire [3:0]  xw_brsize,
  input  wire [15:0] xw_ea,
  input  wire [15:0] xw_wdata,
  // Y read generator, dual-operand instructions
  input  wire        yr_en,
  input  wire        yr_mod,
  input  wire [15:0] yr_ea,
  output reg  [15:0] yr_rdata,
  output reg         yr_valid,
  // DMA port to the shared region
  input  wire        dma_en,
  input  wire        dma_we,
  input  wire        dma_byte,
  input  wire [15:0] dma_ea,
  input  wire [15:0] dma_wdata,
  output wire [15:0] dma_rdata,
  output reg         dma_valid,
  output reg         dma_collide
);
  localparam SH_BASE = RAM_TOP - `SHARED_BYTES; // RQ11
  localparam SH_AW   = 10;
  localparam MAIN_W  = 12;

  // Main RAM holds everything below the shared region (X and lower Y).
  reg [15:0] main_mem [0:(1<<MAIN_W)-1];

  // RQ6: wrap past the end bound back to the start bound.
  function [15:0] modulo_ea;
    input        en;
    input [15:0] ea;
    input [15:0] lo;
    input [15:0] hi;
    begin
      if (en && ea > hi)
        modulo_ea = lo + (ea - hi - 16'h0002);
      else if (en && ea < lo)
        modulo_ea = hi - (lo - ea - 16'h0002);
      else
        modulo_ea = ea;
    end
  endfunction

  // RQ7: mirror the word-index bits below the buffer size.
  function [15:0] bitrev_ea;
    input [15:0] ea;
    input [3:0]  sz;
    integer i;
    begin
      bitrev_ea = ea;
      for (i = 0; i < 15; i = i + 1)
        if (i < sz)
          bitrev_ea[i+1] = ea[sz - i];
    end
  endfunction

  function in_shared;
    input [15:0] ea;
    begin
      in_shared = (ea >= SH_BASE) && (ea < RAM_TOP);
    end
  endfunction

  function in_main;
    input [15:0] ea;
    begin
      in_main = ea < SH_BASE;
    end
  endfunction

  // RQ17: byte lanes from bit 0.
  function [1:0] lanes;
    input       is_byte;
    input       b0;
    begin
      lanes = is_byte ? (b0 ? 2'b10 : 2'b01) : 2'b11;
    end
  endfunction

  wire [15:0] xr_a;
  wire [15:0] xw_m;
  wire [15:0] xw_a;
  wire [15:0] yr_a;
  wire [1:0]  xw_be;
  wire        xw_hit_y;
  wire        yr_in_y;
  wire [15:0] sh_a_rdata;
  wire        xr_sel;
  wire        sh_a_en;
  wire [SH_AW-1:0] sh_a_addr;
  wire        sh_a_we;
  wire        sh_b_en;
  wire [1:0]  sh_b_be;
  wire [SH_AW-1:0] sh_b_addr;
  wire        xr_in_sh;
  wire        xr_in_main;
  wire        xw_in_sh;
  wire        xw_in_main;
  wire        yr_in_sh;
  wire        yr_in_main;
  wire        dma_in_sh;
  reg         xr_valid_next;
  reg         yr_valid_next;
  reg         dma_valid_next;
  reg         dma_collide_next;

  assign xr_a = modulo_ea(xr_mod, xr_ea, mod_start, mod_end); // RQ4
  assign xw_m = modulo_ea(xw_mod, xw_ea, mod_start, mod_end);
  // Bit reversal only when the write lands below the fixed boundary.
  assign xw_hit_y = xw_m >= Y_BASE; // RQ9
  assign xw_a = (xw_bitrev && !xw_hit_y) ?
                bitrev_ea(xw_m, xw_brsize) : xw_m; // RQ7
  assign yr_a = modulo_ea(yr_mod, yr_ea, mod_start, mod_end); // RQ5
  assign yr_in_y = yr_a >= Y_BASE; // RQ1
  assign xw_be = lanes(xw_byte, xw_a[0]); // RQ17

  // Region decode, shared by the DMA port of the shared RAM and the answer flags.
  assign xr_in_sh   = in_shared(xr_a); // RQ10
  assign xr_in_main = in_main(xr_a);
  assign xw_in_sh   = in_shared(xw_a);
  assign xw_in_main = in_main(xw_a); // RQ8
  assign yr_in_sh   = yr_in_y & in_shared(yr_a);
  assign yr_in_main = yr_in_y & in_main(yr_a);
  assign dma_in_sh  = in_shared(dma_ea); // RQ11

  // Processor port of the shared RAM: a write has priority over a read.
  assign xr_sel    = ~(xw_en & in_shared(xw_a));
  assign sh_a_en   = (xw_en & in_shared(xw_a)) | (xr_en & in_shared(xr_a)) |
                     (yr_en & yr_in_y & in_shared(yr_a));
  assign sh_a_addr = (!xr_sel) ? xw_a[SH_AW:1] :
                     (xr_en & in_shared(xr_a)) ? xr_a[SH_AW:1] :
                     yr_a[SH_AW:1];
  assign sh_a_we   = ~xr_sel;
  // The DMA port has its own address and lanes, so it never waits.
  assign sh_b_en   = dma_en & dma_in_sh; // RQ12
  assign sh_b_be   = lanes(dma_byte, dma_ea[0]); // RQ17
  assign sh_b_addr = dma_ea[SH_AW:1];

  shared_region_ram #(
    .AW (SH_AW),
    .DW (16)
  ) u_shared (
    .mclk    (mclk),
    .a_en    (sh_a_en),
    .a_we    (sh_a_we),
    .a_be    (xw_be),
    .a_addr  (sh_a_addr),
    .a_wdata (xw_wdata),
    .a_rdata (sh_a_rdata),
    .b_en    (sh_b_en),
    .b_we    (dma_we),
    .b_be    (sh_b_be),
    .b_addr  (sh_b_addr),
    .b_wdata (dma_wdata),
    .b_rdata (dma_rdata),
    .collide ()
  ); // RQ12

  reg [15:0] xr_main_reg;
  reg [15:0] yr_main_reg;
  reg        xr_sh_reg;
  reg        yr_sh_reg;
  reg        xr_oddb_reg;
  reg        xr_byte_reg;

  // Main RAM: one write port, two read ports, all in the same cycle.
  always @(posedge mclk)
  begin
    if (xw_en && in_main(xw_a)) // RQ8
    begin
      if (xw_be[0]) main_mem[xw_a[MAIN_W:1]][7:0]  <= xw_wdata[7:0];
      if (xw_be[1]) main_mem[xw_a[MAIN_W:1]][15:8] <= xw_wdata[15:8];
    end
    xr_main_reg <= main_mem[xr_a[MAIN_W:1]]; // RQ3
    yr_main_reg <= main_mem[yr_a[MAIN_W:1]]; // RQ2
  end

  // Next values of the answer flags; the flags themselves are flip-flops.
  always @*
  begin
    xr_valid_next    = 1'b0;
    yr_valid_next    = 1'b0;
    dma_valid_next   = 1'b0;
    dma_collide_next = 1'b0;
    if (xr_en)
    begin
      // A shared-region X read loses its slot to a same-cycle X write into the shared region.
      xr_valid_next = xr_in_main | (xr_in_sh & xr_sel); // RQ4
    end
    if (yr_en)
    begin
      // Y shares the processor port, so any X use of it wins.
      yr_valid_next = yr_in_main |
                      (yr_in_sh & xr_sel & ~(xr_en & xr_in_sh)); // RQ5
    end
    if (dma_en)
    begin
      dma_valid_next   = dma_in_sh; // RQ13
      dma_collide_next = dma_we & dma_in_sh & xw_en & xw_in_sh &
                         (sh_b_addr == xw_a[SH_AW:1]); // RQ14
    end
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      xr_valid    <= 1'b0;
      yr_valid    <= 1'b0;
      dma_valid   <= 1'b0;
      dma_collide <= 1'b0;
      xr_sh_reg   <= 1'b0;
      yr_sh_reg   <= 1'b0;
      xr_oddb_reg <= 1'b0;
      xr_byte_reg <= 1'b0;
    end
    else
    begin
      xr_valid    <= xr_valid_next;
      yr_valid    <= yr_valid_next;
      dma_valid   <= dma_valid_next;
      dma_collide <= dma_collide_next;
      xr_sh_reg   <= in_shared(xr_a);
      yr_sh_reg   <= in_shared(yr_a);
      xr_oddb_reg <= xr_a[0];
      xr_byte_reg <= xr_byte;
    end
  end

  reg [15:0] xr_word;
  reg [15:0] yr_word;

  // Word picked for each read path; the shared port serves both.
  always @*
  begin
    xr_word = xr_main_reg;
    if (xr_sh_reg)
      xr_word = sh_a_rdata;
  end

  always @*
  begin
    yr_word = yr_main_reg;
    if (yr_sh_reg)
      yr_word = sh_a_rdata;
  end

  // Read data sits in flip-flops after the lane steering.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      xr_rdata <= 16'h0000;
      yr_rdata <= 16'h0000;
    end
    else
    begin
      xr_rdata <= 16'h0000;
      yr_rdata <= yr_word;
      if (xr_byte_reg) // RQ17
        xr_rdata[7:0] <= xr_oddb_reg ? xr_word[15:8] : xr_word[7:0];
      else
        xr_rdata <= xr_word;
    end
  end
endmodule // dual_space_data_memory
`default_nettype wire

/* hw/dual_space_consts.vh */
`ifndef DUAL_SPACE_CONSTS_VH
`define DUAL_SPACE_CONSTS_VH
`define EA_WIDTH        16
`define DATA_WIDTH      16
`define WORD_ADDR_WIDTH 15
`define Y_BASE_DEFAULT  16'h1800
`define RAM_TOP_DEFAULT 16'h2000
`define SHARED_BYTES    16'h0800
`define MOD_START_RESET 16'h0000
`define MOD_END_RESET   16'hffff
`define BITREV_SIZE_W   4
`endif

/* hw/shared_region_ram.v */
`timescale 1ns/1ps
`default_nettype none
// Two-port word RAM with byte lanes; port a (processor) wins same-word writes.
module shared_region_ram #(
  parameter AW = 10,
  parameter DW = 16
) (
  // Clock
  input  wire          mclk,
  // Processor port
  input  wire          a_en,
  input  wire          a_we,
  input  wire [1:0]    a_be,
  input  wire [AW-1:0] a_addr,
  input  wire [DW-1:0] a_wdata,
  output reg  [DW-1:0] a_rdata,
  // Controller port
  input  wire          b_en,
  input  wire          b_we,
  input  wire [1:0]    b_be,
  input  wire [AW-1:0] b_addr,
  input  wire [DW-1:0] b_wdata,
  output reg  [DW-1:0] b_rdata,
  output wire          collide
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  wire a_wr;
  wire b_wr;
  assign a_wr    = a_en & a_we;
  assign b_wr    = b_en & b_we;
  assign collide = a_wr & b_wr & (a_addr == b_addr); // RQ14

  // Both ports work in the same cycle, so the controller never stalls the core.
  always @(posedge mclk)
  begin
    if (b_wr & ~collide) // RQ16
    begin
      if (b_be[0]) mem[b_addr][7:0]  <= b_wdata[7:0];
      if (b_be[1]) mem[b_addr][15:8] <= b_wdata[15:8];
    end
    if (a_wr) // RQ12
    begin
      if (a_be[0]) mem[a_addr][7:0]  <= a_wdata[7:0];
      if (a_be[1]) mem[a_addr][15:8] <= a_wdata[15:8];
    end
    if (a_en)
      a_rdata <= mem[a_addr];
    if (b_en)
      b_rdata <= mem[b_addr]; // RQ13
  end
endmodule // shared_region_ram
`default_nettype wire

/* tb/dual_space_data_memory_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dsm_checker #(
  parameter [15:0] Y_BASE  = 16'h1800,
  parameter [15:0] RAM_TOP = 16'h2000
) (
  // Watched ports
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        xr_en,
  input wire logic        xr_mod,
  input wire logic [15:0] xr_ea,
  input wire logic        xr_valid,
  input wire logic        xw_en,
  input wire logic        xw_byte,
  input wire logic        xw_mod,
  input wire logic        xw_bitrev,
  input wire logic [15:0] xw_ea,
  input wire logic        yr_en,
  input wire logic        yr_mod,
  input wire logic [15:0] yr_ea,
  input wire logic        yr_valid,
  input wire logic        dma_en,
  input wire logic        dma_we,
  input wire logic        dma_byte,
  input wire logic [15:0] dma_ea,
  input wire logic        dma_valid,
  input wire logic        dma_collide
);
  wire sh = dma_ea >= Y_BASE && dma_ea < RAM_TOP;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_xr_answer: assert property (
    xr_en && !xr_mod && !xw_en && xr_ea < RAM_TOP |=> xr_valid)
    else $error("x read lost");
  a_xr_quiet: assert property (!xr_en |=> !xr_valid)
    else $error("x valid without request");
  a_y_only: assert property (yr_en && !yr_mod && yr_ea < Y_BASE |=> !yr_valid)
    else $error("y answered below its space");
  a_yr_quiet: assert property (!yr_en |=> !yr_valid)
    else $error("y valid without request");
  a_dual_read: assert property (
    xr_en && yr_en && !xr_mod && !yr_mod && !xw_en && xr_ea < Y_BASE
    && yr_ea >= Y_BASE && yr_ea < RAM_TOP |=> xr_valid && yr_valid)
    else $error("dual read incomplete");
  a_dma_free: assert property (dma_en && sh |=> dma_valid)
    else $error("dma access held off");
  a_cpu_wins: assert property (
    dma_en && dma_we && sh && xw_en && !xw_byte && !dma_byte && !xw_mod
    && !xw_bitrev && xw_ea[15:1] == dma_ea[15:1] |=> dma_collide)
    else $error("collision not flagged");
  a_no_collide: assert property (!(dma_en && dma_we) |=> !dma_collide)
    else $error("collision without dma write");
endmodule // dsm_checker
bind dual_space_data_memory dsm_checker #(.Y_BASE(Y_BASE),
  .RAM_TOP(RAM_TOP)) chk (.*);
`default_nettype wire

/* tb/dma_agent.sv */
`timescale 1ns/1ps
`default_nettype none
module dma_agent (
  // Clock
  input  wire logic        mclk,
  // Shared-region port
  output var  logic        dma_en,
  output var  logic        dma_we,
  output var  logic        dma_byte,
  output var  logic [15:0] dma_ea,
  output var  logic [15:0] dma_wdata
);
  initial
  begin
    {dma_en, dma_we, dma_byte} = 3'h0;
    {dma_ea, dma_wdata} = 32'h0;
  end
  // Idle address and data lines show the inverse so stale data never passes for live data.
  task automatic req(input logic we, b, input logic [15:0] ea, d);
    dma_en <= 1'b1;
    dma_we <= we;
    dma_byte <= b;
    dma_ea <= ea;
    dma_wdata <= d;
    @(posedge mclk);
    dma_en <= 1'b0;
    dma_ea <= ~ea;
    dma_wdata <= ~d;
    @(posedge mclk);
  endtask
endmodule // dma_agent
`default_nettype wire

/* tb/dual_space_data_memory_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_space_data_memory_tb;
  logic        mclk, rst, xr_en, xr_byte, xr_mod, xw_en, xw_byte, xw_mod;
  logic        xw_bitrev, yr_en, yr_mod, xr_valid, yr_valid, dma_valid;
  logic        dma_en, dma_we, dma_byte, dma_collide;
  logic [3:0]  xw_brsize;
  logic [15:0] mod_start, mod_end, xr_ea, xw_ea, xw_wdata, yr_ea;
  logic [15:0] dma_ea, dma_wdata, xr_rdata, yr_rdata, dma_rdata;
  int          num_errors, compares;
  dual_space_data_memory uut (.*);
  dma_agent pm (.*);
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] g, e);
    compares++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic xw(input logic [15:0] ea, d, input logic b, r);
    xw_en <= 1'b1;
    xw_ea <= ea;
    xw_wdata <= d;
    xw_byte <= b;
    xw_bitrev <= r;
    @(posedge mclk);
    xw_en <= 1'b0;
    xw_wdata <= ~d;
    @(posedge mclk);
  endtask
  // Y answers only inside its own space, so the expected flag follows ya.
  task automatic rd(input logic xn, yn, b, input logic [15:0] xa, ya, xe, ye);
    logic yv;
    yv = yn && ya >= 16'h1800;
    xr_en <= xn;
    yr_en <= yn;
    xr_ea <= xa;
    yr_ea <= ya;
    xr_byte <= b;
    @(posedge mclk);
    xr_en <= 1'b0;
    yr_en <= 1'b0;
    @(negedge mclk);
    chk(16'(xr_valid), 16'(xn));
    chk(16'(yr_valid), 16'(yv));
    @(negedge mclk);
    if (xn) chk(xr_rdata, xe);
    if (yv) chk(yr_rdata, ye);
    @(posedge mclk);
  endtask
  task automatic s_unified;
    xw(16'h0010, 16'h1234, 1'b0, 1'b0);
    xw(16'h1900, 16'hbeef, 1'b0, 1'b0);
    rd(1'b1, 1'b0, 1'b0, 16'h0010, 16'h0, 16'h1234, 16'h0);
    rd(1'b1, 1'b0, 1'b0, 16'h1900, 16'h0, 16'hbeef, 16'h0);
  endtask
  task automatic s_dual;
    rd(1'b1, 1'b1, 1'b0, 16'h0010, 16'h1900, 16'h1234, 16'hbeef);
    rd(1'b0, 1'b1, 1'b0, 16'h0, 16'h0010, 16'h0, 16'h0);
  endtask
  task automatic s_byte;
    xw(16'h0011, 16'hab00, 1'b1, 1'b0);
    rd(1'b1, 1'b0, 1'b0, 16'h0010, 16'h0, 16'hab34, 16'h0);
    rd(1'b1, 1'b0, 1'b1, 16'h0011, 16'h0, 16'h00ab, 16'h0);
  endtask
  task automatic s_modulo;
    mod_start <= 16'h0010;
    mod_end <= 16'h001e;
    xr_mod <= 1'b1;
    rd(1'b1, 1'b0, 1'b0, 16'h0020, 16'h0, 16'hab34, 16'h0);
    xr_mod <= 1'b0;
    mod_start <= 16'h0000;
    mod_end <= 16'hffff;
  endtask
  task automatic s_bitrev;
    xw_brsize <= 4'h3;
    xw(16'h0102, 16'h5a5a, 1'b0, 1'b1);
    rd(1'b1, 1'b0, 1'b0, 16'h0108, 16'h0, 16'h5a5a, 16'h0);
    xw(16'h1a04, 16'h1111, 1'b0, 1'b1);
    rd(1'b0, 1'b1, 1'b0, 16'h0, 16'h1a04, 16'h0, 16'h1111);
  endtask
  task automatic s_dma;
    fork
      pm.req(1'b1, 1'b0, 16'h1a00, 16'hd00d);
      xw(16'h1a00, 16'hc0de, 1'b0, 1'b0);
      begin
        @(posedge mclk);
        @(negedge mclk);
        chk(16'(dma_collide), 16'h1);
        chk(16'(dma_valid), 16'h1);
      end
    join
    rd(1'b1, 1'b0, 1'b0, 16'h1a00, 16'h0, 16'hc0de, 16'h0);
    pm.req(1'b1, 1'b0, 16'h1a02, 16'h7777);
    pm.req(1'b1, 1'b1, 16'h1a03, 16'h5500);
    fork
      pm.req(1'b0, 1'b0, 16'h1a02, 16'h0);
      rd(1'b0, 1'b1, 1'b0, 16'h0, 16'h1a02, 16'h0, 16'h5577);
    join
    chk(dma_rdata, 16'h5577);
  endtask
  task automatic results;
    if (num_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    rst = 1'b1;
    {xr_en, xr_byte, xr_mod, xw_en, xw_byte, xw_mod, xw_bitrev} = 7'h0;
    {yr_en, yr_mod, xw_brsize} = 6'h0;
    {mod_start, mod_end, xr_ea, xw_ea, xw_wdata, yr_ea} = 96'h0;
    num_errors = 0;
    compares = 0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    mod_end <= 16'hffff;
    @(posedge mclk);
    s_unified;
    s_dual;
    s_byte;
    s_modulo;
    s_bitrev;
    s_dma;
    results;
  end
endmodule // dual_space_data_memory_tb
`default_nettype wire
